/* src/tcbf_pkg.sv */
// Constants for the timer control and buffer-valid flag block
package tcbf_pkg;
   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_ENABLE_CTRL = 6'h00;
   localparam logic [5:0] IDX_MODE_CTRL = 6'h01;
   localparam logic [5:0] IDX_COMPARE_OUTPUT_LEVEL = 6'h02;
   localparam logic [5:0] IDX_SPLIT_SELECT = 6'h03;
   localparam logic [5:0] IDX_COMMAND_DIR_CLEAR = 6'h04;
   localparam logic [5:0] IDX_COMMAND_DIR_SET = 6'h05;
   localparam logic [5:0] IDX_BUFFER_VALID_CLEAR = 6'h06;
   localparam logic [5:0] IDX_BUFFER_VALID_SET = 6'h07;
   localparam int ADDR_LSB = 2;
   // ==========================================================
   // Field positions
   localparam int ENABLE_BIT = 0;
   localparam int AUTO_LOCK_BIT = 3;
   localparam int CMP_EN_LSB = 4;
   localparam int SPLIT_BIT = 0;
   localparam int DIR_BIT = 0;
   localparam int LOCK_UPDATE_BIT = 1;
   localparam int CMD_LSB = 2;
   localparam int PER_BV_BIT = 0;
   localparam int CMP_BV_LSB = 1;
   localparam int NUM_CMP = 3;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   // ==========================================================
   // Command codes
   typedef enum logic [1:0] {
      TCBF_CMD_NONE = 2'b00,
      TCBF_CMD_UPDATE = 2'b01,
      TCBF_CMD_RESTART = 2'b10,
      TCBF_CMD_HARD_RESET = 2'b11
   } tcbf_cmd_e;
endpackage

/* src/tcbf_timer_ctrl.sv */
// Control, command and buffer-valid register logic of a 16-bit timer
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// [R1] Compare output value bits drive waveform levels; writable only while timer disabled.
// [R2] Split select makes the timer run as two 8-bit counters.
// [R3] Split mode switches to an alternate register map.
// [R4] Writing one to a clear register bit clears the shared bit.
// [R5] Writing one to a set register bit sets the shared bit.
// [R6] Command at bits 3:2, lock update bit 1, direction bit 0.
// [R7] Command 0 none, 1 forces update, 2 forces restart.
// [R8] Command 3 forces hard reset, ignored while timer enabled.
// [R9] Command field always reads back zero.
// [R10] Lock update 0: buffers copied to active registers on update.
// [R11] Lock update 1: no buffer transfer on update.
// [R12] Direction 0 counts up, 1 down; hardware or software may change.
// [R13] Compare buffer-valid flag sets on write to its compare buffer.
// [R14] Compare buffer-valid flags clear on an update.
// [R15] Period buffer-valid sets on period buffer write, clears on update.
// [R16] Valid flags: compare2 bit3, compare1 bit2, compare0 bit1, period bit0.
// [R17] Auto lock holds lock update until all enabled compares valid.
// [R18] Next update then transfers buffers and sets lock update again.
// [R19] Zero writes leave bits alone; both registers read underlying bits.
// [R20] All control and valid bits are zero after reset.
module tcbf_timer_ctrl (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_update_condition,
   input wire logic i_period_buffer_write,
   input wire logic [2:0] i_compare_buffer_write,
   input wire logic i_dir_hw_write,
   input wire logic i_dir_hw_value,
   output logic o_timer_enable,
   output logic [2:0] o_compare_enable,
   output logic [2:0] o_waveform_level,
   output logic o_split_mode,
   output logic o_count_down,
   output logic o_lock_update,
   output logic [3:0] o_buffer_valid,
   output logic o_force_update,
   output logic o_force_restart,
   output logic o_force_hard_reset,
   output logic o_buffer_transfer
);

   // ==========================================================
   // State
   typedef struct packed {
      logic wait_req;
      logic [31:0] rdata;
      logic enable;
      logic auto_lock;
      logic [2:0] cmp_en;
      logic [2:0] wave_level;
      logic split;
      logic lock_update;
      logic dir;
      logic [3:0] bv;
      logic upd_p;
      logic rst_p;
      logic hrst_p;
      logic xfer_p;
   } tcbf_state_s;

   tcbf_state_s s_reg;
   tcbf_state_s s_next;

   // ==========================================================
   // Decode helpers
   function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
      hit = (addr[7:tcbf_pkg::ADDR_LSB] == idx);
   endfunction

   // Normal-mode-only registers vanish from the map in split mode
   function automatic logic normal_only(input logic [7:0] addr);
      normal_only = hit(addr, tcbf_pkg::IDX_COMPARE_OUTPUT_LEVEL)
         || hit(addr, tcbf_pkg::IDX_COMMAND_DIR_CLEAR)
         || hit(addr, tcbf_pkg::IDX_COMMAND_DIR_SET); // [R3]
   endfunction

   function automatic logic [7:0] read_byte(input logic [7:0] addr, input tcbf_state_s s);
      logic [7:0] b;
      b = tcbf_pkg::RESET_BYTE;
      if (s.split && normal_only(addr)) begin
         b = tcbf_pkg::RESET_BYTE; // [R3]
      end else if (hit(addr, tcbf_pkg::IDX_ENABLE_CTRL)) begin
         b[tcbf_pkg::ENABLE_BIT] = s.enable;
      end else if (hit(addr, tcbf_pkg::IDX_MODE_CTRL)) begin
         b[tcbf_pkg::AUTO_LOCK_BIT] = s.auto_lock;
         b[tcbf_pkg::CMP_EN_LSB +: tcbf_pkg::NUM_CMP] = s.cmp_en;
      end else if (hit(addr, tcbf_pkg::IDX_COMPARE_OUTPUT_LEVEL)) begin
         b[tcbf_pkg::NUM_CMP-1:0] = s.wave_level;
      end else if (hit(addr, tcbf_pkg::IDX_SPLIT_SELECT)) begin
         b[tcbf_pkg::SPLIT_BIT] = s.split;
      end else if (hit(addr, tcbf_pkg::IDX_COMMAND_DIR_CLEAR)
                   || hit(addr, tcbf_pkg::IDX_COMMAND_DIR_SET)) begin
         // Command bits stay zero on read
         b[tcbf_pkg::LOCK_UPDATE_BIT] = s.lock_update; // [R9] [R19]
         b[tcbf_pkg::DIR_BIT] = s.dir; // [R6]
      end else if (hit(addr, tcbf_pkg::IDX_BUFFER_VALID_CLEAR)
                   || hit(addr, tcbf_pkg::IDX_BUFFER_VALID_SET)) begin
         b[3:0] = s.bv; // [R16] [R19]
      end
      read_byte = b;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      logic req;
      logic wr;
      logic [7:0] wd;
      logic [1:0] cmd;
      logic do_update;
      logic [2:0] en_valid;
      req = 1'b0;
      wr = 1'b0;
      wd = tcbf_pkg::RESET_BYTE;
      cmd = 2'b00;
      do_update = 1'b0;
      en_valid = 3'b000;
      s_next = s_reg;
      s_next.upd_p = 1'b0;
      s_next.rst_p = 1'b0;
      s_next.hrst_p = 1'b0;
      s_next.xfer_p = 1'b0;

      // One wait cycle per access; write commits when waitrequest is low
      req = i_avs_read || i_avs_write;
      s_next.wait_req = !(req && s_reg.wait_req);
      if (req && s_reg.wait_req && i_avs_read) begin
         s_next.rdata = {24'h00_0000, read_byte(i_avs_address, s_reg)};
      end
      wr = i_avs_write && !s_reg.wait_req && i_avs_byteenable[0]
         && !(s_reg.split && normal_only(i_avs_address)); // [R3]
      wd = i_avs_writedata[7:0];

      // Software writes to plain registers
      if (wr && hit(i_avs_address, tcbf_pkg::IDX_ENABLE_CTRL)) begin
         s_next.enable = wd[tcbf_pkg::ENABLE_BIT];
      end
      if (wr && hit(i_avs_address, tcbf_pkg::IDX_MODE_CTRL)) begin
         s_next.auto_lock = wd[tcbf_pkg::AUTO_LOCK_BIT];
         s_next.cmp_en = wd[tcbf_pkg::CMP_EN_LSB +: tcbf_pkg::NUM_CMP];
         if (wd[tcbf_pkg::AUTO_LOCK_BIT]) begin
            s_next.lock_update = 1'b1; // [R17]
         end
      end
      if (wr && hit(i_avs_address, tcbf_pkg::IDX_COMPARE_OUTPUT_LEVEL) && !s_reg.enable) begin
         s_next.wave_level = wd[tcbf_pkg::NUM_CMP-1:0]; // [R1]
      end
      if (wr && hit(i_avs_address, tcbf_pkg::IDX_SPLIT_SELECT)) begin
         s_next.split = wd[tcbf_pkg::SPLIT_BIT]; // [R2]
      end

      // Hardware direction first, so a software write in the same cycle wins
      if (i_dir_hw_write) begin
         s_next.dir = i_dir_hw_value; // [R12]
      end
      if (wr && hit(i_avs_address, tcbf_pkg::IDX_COMMAND_DIR_CLEAR)) begin
         if (wd[tcbf_pkg::LOCK_UPDATE_BIT]) s_next.lock_update = 1'b0; // [R4] [R6]
         if (wd[tcbf_pkg::DIR_BIT]) s_next.dir = 1'b0; // [R4] [R19]
         cmd = wd[tcbf_pkg::CMD_LSB +: 2];
      end
      if (wr && hit(i_avs_address, tcbf_pkg::IDX_COMMAND_DIR_SET)) begin
         if (wd[tcbf_pkg::LOCK_UPDATE_BIT]) s_next.lock_update = 1'b1; // [R5] [R6]
         if (wd[tcbf_pkg::DIR_BIT]) s_next.dir = 1'b1; // [R5] [R19]
         cmd = wd[tcbf_pkg::CMD_LSB +: 2];
      end

      // Commands
      unique case (cmd)
         tcbf_pkg::TCBF_CMD_NONE: begin
         end
         tcbf_pkg::TCBF_CMD_UPDATE: begin
            s_next.upd_p = 1'b1; // [R7]
         end
         tcbf_pkg::TCBF_CMD_RESTART: begin
            s_next.rst_p = 1'b1; // [R7]
         end
         tcbf_pkg::TCBF_CMD_HARD_RESET: begin
            s_next.hrst_p = !s_reg.enable; // [R8]
         end
      endcase

      // Update handling; forced update acts in the same cycle it is written
      do_update = i_update_condition || (cmd == tcbf_pkg::TCBF_CMD_UPDATE);
      if (do_update && !s_reg.lock_update) begin
         s_next.xfer_p = 1'b1; // [R10]
         s_next.bv = 4'h0; // [R14] [R15]
         if (s_reg.auto_lock) begin
            s_next.lock_update = 1'b1; // [R18]
         end
      end // Locked: no transfer, flags kept [R11]

      // Auto lock releases once every enabled compare buffer is valid
      en_valid = s_reg.bv[tcbf_pkg::CMP_BV_LSB +: tcbf_pkg::NUM_CMP] | ~s_reg.cmp_en;
      if (s_reg.auto_lock && s_reg.lock_update && (&en_valid) && !(do_update && !s_reg.lock_update)) begin
         s_next.lock_update = 1'b0; // [R17]
      end

      // Flag clears before sets, so a buffer write never loses to a clear
      if (wr && hit(i_avs_address, tcbf_pkg::IDX_BUFFER_VALID_CLEAR)) begin
         s_next.bv = s_next.bv & ~wd[3:0]; // [R4] [R19]
      end
      if (wr && hit(i_avs_address, tcbf_pkg::IDX_BUFFER_VALID_SET)) begin
         s_next.bv = s_next.bv | wd[3:0]; // [R5] [R16]
      end
      if (i_period_buffer_write) begin
         s_next.bv[tcbf_pkg::PER_BV_BIT] = 1'b1; // [R15]
      end
      for (int i = 0; i < tcbf_pkg::NUM_CMP; i++) begin
         if (i_compare_buffer_write[i]) begin
            s_next.bv[tcbf_pkg::CMP_BV_LSB + i] = 1'b1; // [R13]
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         s_reg <= '0; // [R20]
         s_reg.wait_req <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // Outputs
   assign o_avs_readdata = s_reg.rdata;
   assign o_avs_waitrequest = s_reg.wait_req;
   assign o_timer_enable = s_reg.enable;
   assign o_compare_enable = s_reg.cmp_en;
   assign o_waveform_level = s_reg.wave_level;
   assign o_split_mode = s_reg.split;
   assign o_count_down = s_reg.dir;
   assign o_lock_update = s_reg.lock_update;
   assign o_buffer_valid = s_reg.bv;
   assign o_force_update = s_reg.upd_p;
   assign o_force_restart = s_reg.rst_p;
   assign o_force_hard_reset = s_reg.hrst_p;
   assign o_buffer_transfer = s_reg.xfer_p;

endmodule // tcbf_timer_ctrl

/* testbench/tcbf_timer_ctrl_assertions.sv */
// Concurrent checks on the timer control block ports
`timescale 1ns/1ps
module tcbf_timer_ctrl_assertions (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_update_condition,
   input wire logic i_period_buffer_write,
   input wire logic [2:0] i_compare_buffer_write,
   input wire logic o_timer_enable,
   input wire logic o_split_mode,
   input wire logic o_lock_update,
   input wire logic [3:0] o_buffer_valid,
   input wire logic o_force_update,
   input wire logic o_force_restart,
   input wire logic o_force_hard_reset,
   input wire logic o_buffer_transfer
);
   // ==========================================================
   // Helpers; split mode hides the command pair
   logic cmd_wr;
   logic [3:0] strobes;
   assign cmd_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && !o_split_mode
      && (i_avs_address[7:3] == 5'h02);
   assign strobes = {i_compare_buffer_write, i_period_buffer_write};
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   a_cmd_update: assert property (cmd_wr && i_avs_writedata[3:2] == 2'h1 |=> o_force_update)
      else $error("update command gave no pulse");
   a_cmd_restart: assert property (cmd_wr && i_avs_writedata[3:2] == 2'h2 |=> o_force_restart)
      else $error("restart command gave no pulse");
   a_hard_reset_idle: assert property (cmd_wr && i_avs_writedata[3:2] == 2'h3 && !o_timer_enable
      |=> o_force_hard_reset) else $error("hard reset command lost");
   a_hard_reset_gate: assert property (o_force_hard_reset |-> !$past(o_timer_enable))
      else $error("hard reset while enabled");
   a_cmd_reads_zero: assert property (i_avs_read && !o_avs_waitrequest
      && i_avs_address[7:3] == 5'h02 |-> o_avs_readdata[3:2] == 2'h0) else $error("command read");
   a_lock_blocks: assert property (i_update_condition && o_lock_update |=> !o_buffer_transfer)
      else $error("transfer while locked");
   a_update_moves: assert property (i_update_condition && !o_lock_update |=> o_buffer_transfer)
      else $error("no transfer on update");
   a_update_clears: assert property (i_update_condition && !o_lock_update && !i_avs_write
      && strobes == 4'h0 |=> o_buffer_valid == 4'h0) else $error("flags kept after update");
   a_strobe_sets: assert property (strobes != 4'h0
      |=> (o_buffer_valid & $past(strobes)) == $past(strobes)) else $error("flag not set");
   c_forced_update: cover property (o_force_update);
   c_transfer: cover property (o_buffer_transfer);
   c_lock_release: cover property ($fell(o_lock_update));
endmodule // tcbf_timer_ctrl_assertions

bind tcbf_timer_ctrl tcbf_timer_ctrl_assertions u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_update_condition(i_update_condition), .i_period_buffer_write(i_period_buffer_write),
   .i_compare_buffer_write(i_compare_buffer_write), .o_timer_enable(o_timer_enable),
   .o_split_mode(o_split_mode), .o_lock_update(o_lock_update), .o_buffer_valid(o_buffer_valid),
   .o_force_update(o_force_update), .o_force_restart(o_force_restart),
   .o_force_hard_reset(o_force_hard_reset), .o_buffer_transfer(o_buffer_transfer));

/* testbench/tcbf_timer_ctrl_tb.sv */
// Self-checking testbench for the timer control block
`timescale 1ns/1ps
module tcbf_timer_ctrl_tb;
   // ==========================================================
   // Stimulus and observed signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0, wr = 1'b0, upd = 1'b0, pbw = 1'b0, hdw = 1'b0, hdv = 1'b0;
   logic [2:0] cbw = 3'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wd = 32'h0, rdata;
   logic waitreq, en, split, down, lock, fu, fr, fh, xfer;
   logic [2:0] lvl;
   logic [3:0] bv;
   logic [7:0] q;
   int failures = 0;
   int checked = 0;
   always #50 clk = ~clk;
   tcbf_timer_ctrl u_dut (.i_sys_clk(clk), .i_reset(rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .i_update_condition(upd), .i_period_buffer_write(pbw),
      .i_compare_buffer_write(cbw), .i_dir_hw_write(hdw), .i_dir_hw_value(hdv),
      .o_timer_enable(en), .o_compare_enable(), .o_waveform_level(lvl), .o_split_mode(split),
      .o_count_down(down), .o_lock_update(lock), .o_buffer_valid(bv), .o_force_update(fu),
      .o_force_restart(fr), .o_force_hard_reset(fh), .o_buffer_transfer(xfer));
   // ==========================================================
   // Shared tasks
   task automatic tally_and_finish();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits on waitrequest with a bound, never a fixed latency
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= {idx, 2'b00};
      wd <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      if (n >= 20) chk(8'h01, 8'h00);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(q, exp);
   endtask
   // One-cycle strobes {update, period, compare2..0}
   task automatic pulse(input logic [4:0] p);
      @(posedge clk);
      {upd, pbw, cbw} <= p;
      @(posedge clk);
      {upd, pbw, cbw} <= 5'h00;
      #1;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      for (int i = 0; i < 8; i++) rd_chk(i[5:0], 8'h00);
      bus(1'b1, 6'h05, 8'h03);
      rd_chk(6'h04, 8'h03);
      bus(1'b1, 6'h04, 8'h01);
      rd_chk(6'h05, 8'h02);
      bus(1'b1, 6'h04, 8'h02);
      @(posedge clk);
      {hdw, hdv} <= 2'b11;
      @(posedge clk);
      hdw <= 1'b0;
      #1;
      chk({7'h0, down}, 8'h01);
      bus(1'b1, 6'h02, 8'h05);
      chk({5'h0, lvl}, 8'h05);
      bus(1'b1, 6'h03, 8'h01);
      chk({7'h0, split}, 8'h01);
      rd_chk(6'h02, 8'h00);
      bus(1'b1, 6'h03, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_cmds();
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 6'h05, 8'(c << 2));
         chk({5'h0, fu, fr, fh}, 8'((8 >> c) & 7));
      end
      rd_chk(6'h05, 8'h01);
      bus(1'b1, 6'h00, 8'h01);
      bus(1'b1, 6'h02, 8'h02);
      chk({5'h0, lvl}, 8'h05);
      bus(1'b1, 6'h04, 8'h0D);
      chk({6'h0, down, fh}, 8'h00);
      bus(1'b1, 6'h00, 8'h00);
      $display("test cmds done");
   endtask
   task automatic t_flags();
      pulse(5'h04);
      chk({4'h0, bv}, 8'h08);
      pulse(5'h0B);
      chk({4'h0, bv}, 8'h0F);
      pulse(5'h10);
      chk({3'h0, xfer, bv}, 8'h10);
      bus(1'b1, 6'h07, 8'h05);
      bus(1'b1, 6'h06, 8'h01);
      rd_chk(6'h07, 8'h04);
      bus(1'b1, 6'h05, 8'h02);
      pulse(5'h10);
      chk({3'h0, xfer, bv}, 8'h04);
      bus(1'b1, 6'h04, 8'h02);
      $display("test flags done");
   endtask
   task automatic t_auto();
      bus(1'b1, 6'h01, 8'h18);
      chk({7'h0, lock}, 8'h01);
      pulse(5'h01);
      @(posedge clk);
      #1;
      chk({7'h0, lock}, 8'h00);
      pulse(5'h10);
      chk({2'h0, xfer, bv, lock}, 8'h21);
      $display("test auto lock done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_cmds();
      t_flags();
      t_auto();
      tally_and_finish();
   end
   // Whole run is about 120 cycles
   initial begin
      #500_000;
      failures++;
      tally_and_finish();
   end
endmodule // tcbf_timer_ctrl_tb
